/* File: wdtu_pkg.sv */
package wdtu_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_TCS_WR   = 16'hFF74;
    localparam logic [15:0] ADDR_RCS_WR   = 16'hFF76;
    localparam logic [15:0] ADDR_TCS_RD   = 16'hFF74;
    localparam logic [15:0] ADDR_CNT_RD   = 16'hFF75;
    localparam logic [15:0] ADDR_RCS_RD   = 16'hFF77;

    // ------------------------------------------------------------
    // Write keys in the upper byte of a word write
    // ------------------------------------------------------------
    localparam logic [7:0]  KEY_COUNTER   = 8'h5A;
    localparam logic [7:0]  KEY_CONTROL   = 8'hA5;
    localparam logic [7:0]  KEY_RCS_BITS  = 8'h5A;
    localparam logic [7:0]  KEY_WD_OVERFLOW_FLAG_CLR  = 8'hA5;
    localparam logic [7:0]  WD_OVERFLOW_FLAG_CLR_DATA = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TCS_OVF_BIT   = 7;
    localparam int TCS_MODE_BIT  = 6;
    localparam int TCS_TME_BIT   = 5;
    localparam int TCS_CKS_MSB   = 2;
    localparam int RCS_WD_OVERFLOW_FLAG_BIT  = 7;
    localparam int RCS_CHIP_RESET_ENABLE_BIT  = 6;
    localparam int RCS_RESET_TYPE_SELECT_BIT  = 5;

    // ------------------------------------------------------------
    // Reset values and fixed read bits
    // ------------------------------------------------------------
    localparam logic [7:0]  TCS_FIXED_ONES = 8'h18;
    localparam logic [7:0]  RCS_FIXED_ONES = 8'h1F;
    localparam logic [7:0]  CNT_RESET      = 8'h00;
    localparam logic [7:0]  CNT_ALL_ONES   = 8'hFF;
    localparam logic [2:0]  CKS_RESET      = 3'h0;
    localparam logic [7:0]  RD_UNMAPPED    = 8'h00;

    // ------------------------------------------------------------
    // Timing: one state is one system clock period
    // ------------------------------------------------------------
    localparam int CLK_PER_STATE      = 1;
    localparam int CHIP_RST_STATES    = 518;
    localparam int WR_BLOCK_STATES    = 132;
    localparam int CHIP_RST_CYCLES    = CHIP_RST_STATES * CLK_PER_STATE;
    localparam int WR_BLOCK_CYCLES    = WR_BLOCK_STATES * CLK_PER_STATE;

    // ------------------------------------------------------------
    // Prescaler taps, as log2 of the divisor per clock-select code
    // ------------------------------------------------------------
    localparam int PRE_W = 17;
    localparam logic [7:0][4:0] TAP_LOG2_DEFAULT = {
        5'h11, 5'h0F, 5'h0D, 5'h0B, 5'h09, 5'h07, 5'h05, 5'h01
    };

endpackage

/* File: wdtu_hold_timer.sv */
module wdtu_hold_timer
    import wdtu_pkg::*;
#(
    parameter int COUNT = 4
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic start,
    output logic      active
);

    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LOAD = CW'(COUNT - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          active_q;
    logic          active_d;

    // Restart on a new start keeps the full length from the latest event
    always_comb begin
        cnt_d    = cnt_q;
        active_d = active_q;
        if (start) begin
            cnt_d    = LOAD;
            active_d = 1'b1;
        end else if (active_q) begin
            if (cnt_q == '0) begin
                active_d = 1'b0;
            end else begin
                cnt_d = cnt_q - CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q    <= '0;
            active_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            active_q <= active_d;
        end
    end

    assign active = active_q;

endmodule

/* File: wdtu_prescaler.sv */
module wdtu_prescaler
    import wdtu_pkg::*;
#(
    parameter int              WIDTH    = PRE_W,
    parameter logic [7:0][4:0] TAP_LOG2 = TAP_LOG2_DEFAULT
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] clkSel,
    output logic            tick
);

    logic [WIDTH-1:0] div_q;
    logic [WIDTH-1:0] div_d;
    logic [WIDTH-1:0] mask;

    // ------------------------------------------------------------
    // Free-running divider; taps never restart, so a mid-run select
    // change can give one short period
    // ------------------------------------------------------------
    always_comb begin
        div_d = div_q + WIDTH'(1);
        mask  = WIDTH'((64'h1 << TAP_LOG2[clkSel]) - 64'h1);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    assign tick = ((div_q & mask) == mask);

endmodule

/* File: wdtu_watchdog_unit.sv */
// Overview of operation
// - Counter increments on selected tick only while enabled; disable clears it to zero.
// - Counter wrap from all ones to zero sets the overflow flag in interval mode.
// - Flags clear only by reading them as 1 then writing 0 (1 ignored), or for the overflow flag by watchdog overflow.
// - Watchdog overflow clears the overflow flag, with or without chip reset enabled.
// - Control bit 6 picks interval mode (0) or watchdog mode (1), resets 0.
// - Clock-select codes 000, 101, 110 give divide by 2, 8192, 32768.
// - Reserved control bits 4,3 and reset-control bits 4..0 read one.
// - Watchdog overflow flag sets only on overflow in watchdog mode.
// - Chip reset enable gates internal reset; counter and control reset regardless.
// - Reset-type select 0 means power-on reset; software never writes 1.
// - Reset-control register initialises only from pin reset, survives internal reset.
// - Pin reset coinciding with overflow wins and leaves watchdog flag clear.
// - Internal reset output stays asserted for 518 system-clock states.
// - Interval mode overflow sets flag; interrupt request follows the flag.
// - Word write at shared address: key 5A to counter, A5 to control.
// - Word write key 5A at reset-control address loads enable and select bits.
// - Word write A5 with zero data clears watchdog flag, keeps other bits.
// - Byte reads at three distinct addresses return control, counter, reset-control.
// - Counter write in the same cycle as a tick keeps the written value.
// - For 132 states after overflow writes ignored, watchdog flag reads not acknowledged.
module wdtu_watchdog_unit
    import wdtu_pkg::*;
#(
    parameter logic [7:0][4:0] TAP_LOG2      = TAP_LOG2_DEFAULT,
    parameter int              CHIP_RST_LEN  = CHIP_RST_CYCLES,
    parameter int              WR_BLOCK_LEN  = WR_BLOCK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] busAddr,
    input  wire logic        busWriteEn,
    input  wire logic        busWordAccess,
    input  wire logic [15:0] busWdata,
    input  wire logic        busReadEn,
    output logic [7:0]       busRdata,
    output logic             chipResetOut,
    output logic             resetTypeSel,
    output logic             intervalIrq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       ovf_q;
    logic       ovf_d;
    logic       mode_q;
    logic       mode_d;
    logic       tme_q;
    logic       tme_d;
    logic [2:0] cks_q;
    logic [2:0] cks_d;
    logic       wd_overflow_flag_q;
    logic       wd_overflow_flag_d;
    logic       chip_reset_enable_q;
    logic       chip_reset_enable_d;
    logic       reset_type_select_q;
    logic       reset_type_select_d;
    logic       ovfArmed_q;
    logic       ovfArmed_d;
    logic       wovfArmed_q;
    logic       wovfArmed_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       irq_q;
    logic       irq_d;

    logic       tick;
    logic       overflow;
    logic       wdOverflow;
    logic       chipRstStart;
    logic       blocked;
    logic       chipRstActive;

    logic       wrWord;
    logic       wrCounter;
    logic       wrControl;
    logic       wrRcsBits;
    logic       wrWovfClr;
    logic       rdTcs;
    logic       rdRcs;
    logic [7:0] tcsView;
    logic [7:0] rcsView;

    // ------------------------------------------------------------
    // Clock source
    // ------------------------------------------------------------
    wdtu_prescaler #(
        .WIDTH    (PRE_W),
        .TAP_LOG2 (TAP_LOG2)
    ) u_prescaler (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .clkSel   (cks_q),
        .tick     (tick)
    );

    // ------------------------------------------------------------
    // Hold windows after overflow
    // ------------------------------------------------------------
    wdtu_hold_timer #(
        .COUNT   (CHIP_RST_LEN)
    ) u_chip_rst (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (chipRstStart),
        .active  (chipRstActive)
    );

    wdtu_hold_timer #(
        .COUNT   (WR_BLOCK_LEN)
    ) u_wr_block (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (overflow),
        .active  (blocked)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Byte writes never reach these registers; the key guards stray stores
    always_comb begin
        wrWord    = busWriteEn && busWordAccess && !blocked;
        wrCounter = wrWord && busAddr == ADDR_TCS_WR
                    && busWdata[15:8] == KEY_COUNTER;
        wrControl = wrWord && busAddr == ADDR_TCS_WR
                    && busWdata[15:8] == KEY_CONTROL;
        wrRcsBits = wrWord && busAddr == ADDR_RCS_WR
                    && busWdata[15:8] == KEY_RCS_BITS;
        wrWovfClr = wrWord && busAddr == ADDR_RCS_WR
                    && busWdata[15:8] == KEY_WD_OVERFLOW_FLAG_CLR
                    && busWdata[7:0] == WD_OVERFLOW_FLAG_CLR_DATA;
        rdTcs     = busReadEn && busAddr == ADDR_TCS_RD;
        rdRcs     = busReadEn && busAddr == ADDR_RCS_RD;
    end

    // ------------------------------------------------------------
    // Overflow detection
    // ------------------------------------------------------------
    // A tick lost to a counter write cannot overflow either
    always_comb begin
        overflow     = tme_q && tick && !wrCounter && cnt_q == CNT_ALL_ONES;
        wdOverflow   = overflow && mode_q;
        chipRstStart = wdOverflow && chip_reset_enable_q;
    end

    // ------------------------------------------------------------
    // Counter and control/status
    // ------------------------------------------------------------
    always_comb begin
        cnt_d      = cnt_q;
        ovf_d      = ovf_q;
        mode_d     = mode_q;
        tme_d      = tme_q;
        cks_d      = cks_q;
        ovfArmed_d = ovfArmed_q;
        if (rdTcs && ovf_q) begin
            ovfArmed_d = 1'b1;
        end
        if (wrControl) begin
            mode_d = busWdata[TCS_MODE_BIT];
            tme_d  = busWdata[TCS_TME_BIT];
            cks_d  = busWdata[TCS_CKS_MSB:0];
            if (!busWdata[TCS_OVF_BIT] && ovfArmed_q) begin
                ovf_d      = 1'b0;
                ovfArmed_d = 1'b0;
            end
        end
        if (wrCounter) begin
            cnt_d = busWdata[7:0];
        end else if (tme_q && tick) begin
            cnt_d = cnt_q + 8'h01;
        end
        if (!tme_d) begin
            cnt_d = CNT_RESET;
        end
        if (overflow) begin
            ovf_d = 1'b1;
        end
        // Watchdog overflow resets counter and control, clearing the flag too
        if (wdOverflow) begin
            cnt_d      = CNT_RESET;
            ovf_d      = 1'b0;
            mode_d     = 1'b0;
            tme_d      = 1'b0;
            cks_d      = CKS_RESET;
            ovfArmed_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q      <= CNT_RESET;
            ovf_q      <= 1'b0;
            mode_q     <= 1'b0;
            tme_q      <= 1'b0;
            cks_q      <= CKS_RESET;
            ovfArmed_q <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            ovf_q      <= ovf_d;
            mode_q     <= mode_d;
            tme_q      <= tme_d;
            cks_q      <= cks_d;
            ovfArmed_q <= ovfArmed_d;
        end
    end

    // ------------------------------------------------------------
    // Reset control/status
    // ------------------------------------------------------------
    // Only the pin reset reaches these bits, never the internal reset
    always_comb begin
        wd_overflow_flag_d      = wd_overflow_flag_q;
        chip_reset_enable_d      = chip_reset_enable_q;
        reset_type_select_d      = reset_type_select_q;
        wovfArmed_d = wovfArmed_q;
        if (rdRcs && wd_overflow_flag_q && !blocked) begin
            wovfArmed_d = 1'b1;
        end
        if (wrRcsBits) begin
            chip_reset_enable_d = busWdata[RCS_CHIP_RESET_ENABLE_BIT];
            reset_type_select_d = busWdata[RCS_RESET_TYPE_SELECT_BIT];
        end
        if (wrWovfClr && wovfArmed_q) begin
            wd_overflow_flag_d      = 1'b0;
            wovfArmed_d = 1'b0;
        end
        // Setting beats a simultaneous clear
        if (wdOverflow) begin
            wd_overflow_flag_d      = 1'b1;
            wovfArmed_d = 1'b0;
        end
    end

    // Pin reset wins over a coincident overflow and leaves the flag clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wd_overflow_flag_q      <= 1'b0;
            chip_reset_enable_q      <= 1'b0;
            reset_type_select_q      <= 1'b0;
            wovfArmed_q <= 1'b0;
        end else begin
            wd_overflow_flag_q      <= wd_overflow_flag_d;
            chip_reset_enable_q      <= chip_reset_enable_d;
            reset_type_select_q      <= reset_type_select_d;
            wovfArmed_q <= wovfArmed_d;
        end
    end

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    always_comb begin
        tcsView = TCS_FIXED_ONES;
        tcsView[TCS_OVF_BIT]  = ovf_q;
        tcsView[TCS_MODE_BIT] = mode_q;
        tcsView[TCS_TME_BIT]  = tme_q;
        tcsView[TCS_CKS_MSB:0] = cks_q;
        rcsView = RCS_FIXED_ONES;
        rcsView[RCS_WD_OVERFLOW_FLAG_BIT] = wd_overflow_flag_q;
        rcsView[RCS_CHIP_RESET_ENABLE_BIT] = chip_reset_enable_q;
        rcsView[RCS_RESET_TYPE_SELECT_BIT] = reset_type_select_q;
        rdata_d = rdata_q;
        if (busReadEn) begin
            unique case (busAddr)
                ADDR_TCS_RD: rdata_d = tcsView;
                ADDR_CNT_RD: rdata_d = cnt_q;
                ADDR_RCS_RD: rdata_d = rcsView;
                default:     rdata_d = RD_UNMAPPED;
            endcase
        end
        // Request level tracks the flag, only outside watchdog mode
        irq_d = ovf_d && !mode_d;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= RD_UNMAPPED;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign busRdata     = rdata_q;
    assign intervalIrq  = irq_q;
    assign chipResetOut = chipRstActive;
    assign resetTypeSel = reset_type_select_q;

endmodule

/* File: wdtu_watchdog_unit_monitor.sv */
module wdtu_watchdog_unit_monitor
    import wdtu_pkg::*;
#(
    parameter int CHIP_RST_LEN = CHIP_RST_CYCLES
) (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [15:0] busAddr,
    input wire logic        busWriteEn,
    input wire logic        busWordAccess,
    input wire logic [15:0] busWdata,
    input wire logic        busReadEn,
    input wire logic [7:0]  busRdata,
    input wire logic        chipResetOut,
    input wire logic        resetTypeSel,
    input wire logic        intervalIrq
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Counts high cycles of the chip reset; a fixed repetition would be too long to unroll
    logic [9:0] hiCnt_q;
    logic [9:0] hiCnt_d;
    logic       mapped;
    logic       rcsKey;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    always_comb begin
        hiCnt_d = chipResetOut ? hiCnt_q + 10'h001 : 10'h000;
        mapped  = busAddr inside {ADDR_TCS_RD, ADDR_CNT_RD, ADDR_RCS_RD};
        // Registered through $past below, so no sequence method is needed
        rcsKey  = busWriteEn && busWordAccess && busAddr == ADDR_RCS_WR && busWdata[15:8] == KEY_RCS_BITS;
    end

    always_ff @(posedge sys_clk) begin
        hiCnt_q <= sys_rst ? 10'h000 : hiCnt_d;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_rd(a);
        busReadEn && busAddr == a;
    endsequence

    a_reset_quiet: assert property ($fell(sys_rst) |-> !chipResetOut && !intervalIrq && !resetTypeSel)
        else $error("outputs not idle after reset");
    a_rst_length: assert property (chipResetOut |-> hiCnt_q < CHIP_RST_LEN)
        else $error("chip reset too long");
    a_rst_full: assert property ($fell(chipResetOut) && !$past(sys_rst) |-> hiCnt_q == CHIP_RST_LEN)
        else $error("chip reset too short");
    a_rcs_fixed: assert property (s_rd(ADDR_RCS_RD) |=> busRdata[4:0] == 5'h1F)
        else $error("reset control low bits not ones");
    a_tcs_fixed: assert property (s_rd(ADDR_TCS_RD) |=> busRdata[4:3] == 2'h3)
        else $error("timer control bits 4,3 not ones");
    a_unmapped_zero: assert property (busReadEn && !mapped |=> busRdata == RD_UNMAPPED)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!busReadEn |=> $stable(busRdata))
        else $error("read data changed without read");
    a_irq_min: assert property ($rose(intervalIrq) |-> intervalIrq [*3])
        else $error("interrupt withdrawn inside blocked window");
    a_reset_type_select_source: assert property ($changed(resetTypeSel) |->
        $past(rcsKey) && resetTypeSel == $past(busWdata[5]))
        else $error("reset select changed without keyed write");
    a_byte_ignored: assert property (busWriteEn && !busWordAccess |=> $stable(resetTypeSel))
        else $error("byte write took effect");
endmodule

/* File: wdtu_cpu_model.sv */
module wdtu_cpu_model
    import wdtu_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [7:0]  busRdata,
    output logic [15:0]      busAddr,
    output logic             busWriteEn,
    output logic             busWordAccess,
    output logic [15:0]      busWdata,
    output logic             busReadEn
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        busAddr = 16'h0000;
        busWriteEn = 1'b0;
        busWordAccess = 1'b0;
        busWdata = 16'h0000;
        busReadEn = 1'b0;
    end

    // ------------------------------------------------------------
    // Bus cycles, launched on the falling edge
    // ------------------------------------------------------------
    // Released lines show the inverse so a stale value never looks valid
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic word);
        @(negedge sys_clk);
        busAddr = a;
        busWdata = d;
        busWordAccess = word;
        busWriteEn = 1'b1;
        @(negedge sys_clk);
        busWriteEn = 1'b0;
        busAddr = ~a;
        busWdata = ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        busAddr = a;
        busReadEn = 1'b1;
        @(negedge sys_clk);
        busReadEn = 1'b0;
        busAddr = ~a;
        v = busRdata;
    endtask

    // Stops the count before any mode or clock change
    task automatic cfg(input logic [7:0] ctl);
        wr(ADDR_TCS_WR, {KEY_CONTROL, 8'h00}, 1'b1);
        wr(ADDR_TCS_WR, {KEY_CONTROL, ctl}, 1'b1);
    endtask

    // Select bit always written 0; power-on reset only
    task automatic setRcs(input logic [7:0] d);
        wr(ADDR_RCS_WR, {KEY_RCS_BITS, d & 8'hDF}, 1'b1);
    endtask

    task automatic clrTcs(input logic [7:0] ctl);
        logic [7:0] v;
        rd(ADDR_TCS_RD, v);
        wr(ADDR_TCS_WR, {KEY_CONTROL, ctl & 8'h7F}, 1'b1);
    endtask

    task automatic clrWovf;
        logic [7:0] v;
        rd(ADDR_RCS_RD, v);
        wr(ADDR_RCS_WR, {KEY_WD_OVERFLOW_FLAG_CLR, WD_OVERFLOW_FLAG_CLR_DATA}, 1'b1);
    endtask
endmodule

/* File: watchdog_interval_timer_test.sv */
module watchdog_interval_timer_test
    import wdtu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] busAddr;
    logic        busWriteEn;
    logic        busWordAccess;
    logic [15:0] busWdata;
    logic        busReadEn;
    logic [7:0]  busRdata;
    logic        chipResetOut;
    logic        resetTypeSel;
    logic        intervalIrq;
    logic [7:0]  v;
    int          bad_count = 0;
    int          n_compared = 0;
    int          n;

    always #25 sys_clk = ~sys_clk;

    // Short hold lengths keep the run brief
    wdtu_watchdog_unit #(.CHIP_RST_LEN(8), .WR_BLOCK_LEN(4)) u_wdtu_watchdog_unit (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWriteEn(busWriteEn),
        .busWordAccess(busWordAccess), .busWdata(busWdata), .busReadEn(busReadEn), .busRdata(busRdata),
        .chipResetOut(chipResetOut), .resetTypeSel(resetTypeSel), .intervalIrq(intervalIrq));

    wdtu_cpu_model u_wdtu_cpu_model (
        .sys_clk(sys_clk), .busRdata(busRdata), .busAddr(busAddr), .busWriteEn(busWriteEn),
        .busWordAccess(busWordAccess), .busWdata(busWdata), .busReadEn(busReadEn));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic rdChk(input string nm, input logic [15:0] a, input logic [7:0] exp);
        u_wdtu_cpu_model.rd(a, v);
        chk(nm, v, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdChk("tcs", ADDR_TCS_RD, 8'h18);
        rdChk("cnt", ADDR_CNT_RD, 8'h00);
        rdChk("rcs", ADDR_RCS_RD, 8'h1F);
        rdChk("unmapped", 16'hFF70, 8'h00);
        chk("reset_type_select", {7'h00, resetTypeSel}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_keys;
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'hA560, 1'b0);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'h3360, 1'b1);
        rdChk("tcs_guard", ADDR_TCS_RD, 8'h18);
        u_wdtu_cpu_model.wr(ADDR_RCS_WR, 16'h5A40, 1'b0);
        rdChk("rcs_byte", ADDR_RCS_RD, 8'h1F);
        u_wdtu_cpu_model.setRcs(8'hFF);
        rdChk("rcs_bits", ADDR_RCS_RD, 8'h5F);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'hA5FF, 1'b1);
        rdChk("tcs_bits", ADDR_TCS_RD, 8'h7F);
        u_wdtu_cpu_model.setRcs(8'h00);
        $display("test keys done");
    endtask

    task automatic t_clock;
        logic [2:0] code [4] = '{3'h0, 3'h1, 3'h5, 3'h6};
        int         lg [4] = '{1, 5, 13, 15};
        int         nt [4] = '{8, 8, 2, 1};
        for (int i = 0; i < 4; i++) begin
            u_wdtu_cpu_model.cfg(8'h20 | {5'h00, code[i]});
            repeat (nt[i] << lg[i]) @(negedge sys_clk);
            u_wdtu_cpu_model.rd(ADDR_CNT_RD, v);
            chk("rate", {7'h00, v >= nt[i] - 1 && v <= nt[i] + 1}, 8'h01);
            u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'hA500, 1'b1);
            rdChk("halted", ADDR_CNT_RD, 8'h00);
        end
        $display("test clock done");
    endtask

    task automatic t_interval;
        u_wdtu_cpu_model.cfg(8'h20);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'h5AFE, 1'b1);
        for (n = 0; n < 40 && !intervalIrq; n++) @(negedge sys_clk);
        chk("irq_set", {7'h00, intervalIrq}, 8'h01);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'h5A33, 1'b1);
        u_wdtu_cpu_model.rd(ADDR_CNT_RD, v);
        chk("blocked", {7'h00, v == 8'h33}, 8'h00);
        rdChk("no_wd_overflow_flag", ADDR_RCS_RD, 8'h1F);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'hA520, 1'b1);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'hA5A0, 1'b1);
        chk("irq_kept", {7'h00, intervalIrq}, 8'h01);
        u_wdtu_cpu_model.clrTcs(8'h00);
        chk("irq_clr", {7'h00, intervalIrq}, 8'h00);
        rdChk("tcs_clr", ADDR_TCS_RD, 8'h18);
        $display("test interval done");
    endtask

    task automatic t_watchdog(input logic chip_reset_enable);
        u_wdtu_cpu_model.setRcs({1'b0, chip_reset_enable, 6'h00});
        u_wdtu_cpu_model.cfg(8'h60);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'h5AFE, 1'b1);
        for (n = 0; n < 40 && !chipResetOut; n++) @(negedge sys_clk);
        for (n = 0; n < 600 && chipResetOut; n++) @(negedge sys_clk);
        chk("rst_len", 8'(n), chip_reset_enable ? 8'h08 : 8'h00);
        rdChk("wd_overflow_flag", ADDR_RCS_RD, {2'h2 | 2'(chip_reset_enable), 6'h1F});
        rdChk("tcs_wd", ADDR_TCS_RD, 8'h18);
        u_wdtu_cpu_model.wr(ADDR_RCS_WR, 16'hA501, 1'b1);
        rdChk("wd_overflow_flag_bad", ADDR_RCS_RD, {2'h2 | 2'(chip_reset_enable), 6'h1F});
        u_wdtu_cpu_model.clrWovf();
        rdChk("wd_overflow_flag_clr", ADDR_RCS_RD, {1'b0, chip_reset_enable, 6'h1F});
        $display("test watchdog done");
    endtask

    // Pin reset lands one clock before the overflow edge; the pin must win
    task automatic t_pin_reset;
        u_wdtu_cpu_model.setRcs(8'h40);
        u_wdtu_cpu_model.cfg(8'h60);
        u_wdtu_cpu_model.wr(ADDR_TCS_WR, 16'h5AFF, 1'b1);
        sys_rst = 1'b1;
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk("rst_pin", {7'h00, chipResetOut}, 8'h00);
        rdChk("rcs_pin", ADDR_RCS_RD, 8'h1F);
        rdChk("tcs_pin", ADDR_TCS_RD, 8'h18);
        rdChk("cnt_pin", ADDR_CNT_RD, 8'h00);
        $display("test pin reset done");
    endtask

    initial begin
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_reset();
        t_keys();
        t_clock();
        t_interval();
        t_watchdog(1'b1);
        t_watchdog(1'b0);
        t_pin_reset();
        conclude();
    end

    // Tests take about 50k cycles
    initial begin
        repeat (90000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
endmodule

bind wdtu_watchdog_unit wdtu_watchdog_unit_monitor #(.CHIP_RST_LEN(CHIP_RST_LEN)) u_wdtu_watchdog_unit_monitor (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWriteEn(busWriteEn),
    .busWordAccess(busWordAccess), .busWdata(busWdata), .busReadEn(busReadEn), .busRdata(busRdata),
    .chipResetOut(chipResetOut), .resetTypeSel(resetTypeSel), .intervalIrq(intervalIrq));
